// ==== logic/sair_defines.svh ====
// Constants for the serial audio source controller
`ifndef SAIR_DEFINES_SVH
`define SAIR_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SAIR_OFF_CTRL 12'h000
`define SAIR_OFF_STATUS 12'h004
`define SAIR_OFF_L0 12'h008
`define SAIR_OFF_R0 12'h00c
`define SAIR_OFF_L1 12'h010
`define SAIR_OFF_R1 12'h014
`define SAIR_OFF_DEVCFG 12'h018

// ----------------------------------------------------------------
// Reset values and field codes
// ----------------------------------------------------------------
`define SAIR_CTRL_RST 8'h00
`define SAIR_DEVCFG_RST 5'h01
`define SAIR_FMT_I2S 2'h0
`define SAIR_FMT_LEFT 2'h1
`define SAIR_FMT_RIGHT 2'h2
`define SAIR_RATIO_32 2'h0
`define SAIR_RATIO_48 2'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SAIR_CLK_NS 100
`define SAIR_SCLK_PERIOD_NS 800
`define SAIR_SCLK_HALF ((`SAIR_SCLK_PERIOD_NS / `SAIR_CLK_NS) / 2)
`define SAIR_MCLK_HALF 1

`endif

// ==== logic/sair_host.sv ====
// Serial audio source: drives clocks and data toward the receiver
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "sair_defines.svh"

module sair_host #(
  parameter int SCLK_HALF = `SAIR_SCLK_HALF,
  parameter int MCLK_HALF = `SAIR_MCLK_HALF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Link toward the receiver
  output sair_pkg::sair_link_t link_o,
  // Receiver control levels
  output sair_pkg::sair_devctl_t devctl_o
);

  sair_pkg::sair_state_t s_q;
  sair_pkg::sair_state_t s_d;

  // ----------------------------------------------------------------
  // Frame helpers
  // ----------------------------------------------------------------

  // Half-frame length in bit clocks
  function automatic logic [5:0] sair_half(input logic [1:0] ratio);
    if (ratio == `SAIR_RATIO_32) begin
      sair_half = 6'h10;
    end else if (ratio == `SAIR_RATIO_48) begin
      sair_half = 6'h18;
    end else begin
      sair_half = 6'h20; // Illegal code runs as 64 fs
    end
  endfunction : sair_half

  // Word length, limited to the slot
  function automatic logic [5:0] sair_wl(input sair_pkg::sair_cfg_t c);
    logic [5:0] w;
    logic [5:0] h;
    w = (c.wlen == 2'h3) ? 6'h18 : 6'h10 + {3'h0, c.wlen, 1'b0};
    h = sair_half(c.ratio);
    sair_wl = (w > h) ? h : w;
  endfunction : sair_wl

  // Word clock and both data bits for one frame position
  function automatic logic [2:0] sair_bits(input logic [5:0] pos, input sair_pkg::sair_cfg_t c,
                                           input sair_pkg::sair_samp_t cur, input logic [1:0] prev_lsb);
    logic [5:0] h;
    logic [5:0] wl;
    logic [5:0] b;
    logic [5:0] k;
    logic [5:0] off;
    logic chan;
    logic send;
    logic lr;
    logic [1:0] d;
    logic [23:0] w0;
    logic [23:0] w1;
    h = sair_half(c.ratio);
    wl = sair_wl(c);
    chan = (pos >= h);
    b = chan ? pos - h : pos;
    w0 = chan ? cur.r0 : cur.l0;
    w1 = chan ? cur.r1 : cur.l1;
    off = h - wl;
    k = 6'h00;
    send = 1'b0;
    d = 2'b00;
    lr = ~chan;
    if (c.fmt == `SAIR_FMT_I2S) begin
      lr = chan;
      if (b == 6'h00) begin
        // Slot start carries the previous word's LSB only if it fills the slot
        if (wl == h) begin
          d = chan ? {cur.l1[0], cur.l0[0]} : prev_lsb;
        end
      end else begin
        k = b - 6'h01;
        send = (k < wl);
      end
    end else if (c.fmt == `SAIR_FMT_RIGHT) begin
      send = (b >= off);
      k = b - off;
    end else begin
      k = b;
      send = (k < wl);
    end
    if (send) begin
      // MSB first; low word-length bits of the signed sample
      d = {w1[5'(wl - 6'h01 - k)], w0[5'(wl - 6'h01 - k)]};
    end
    sair_bits = {lr, d};
  endfunction : sair_bits

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0] np;
    logic [5:0] last;
    logic [2:0] bits;
    logic wr;
    logic rd;
    logic fs;
    sair_pkg::sair_cfg_t ncfg;
    np = 6'h00;
    last = 6'h00;
    bits = 3'h0;
    fs = 1'b0;
    ncfg = '0;
    s_d = s_q;
    wr = psel_i & penable_i & pwrite_i;
    rd = psel_i & ~penable_i;
    ncfg.fmt = s_q.ctrl[2:1];
    ncfg.wlen = s_q.ctrl[4:3];
    ncfg.ratio = s_q.ctrl[6:5];

    // Master clock divider, stopped when disabled
    if (!s_q.ctrl[7]) begin
      s_d.mdiv = 8'h00;
      s_d.link.mclk = 1'b0;
    end else if (s_q.mdiv == 8'(MCLK_HALF - 1)) begin
      s_d.mdiv = 8'h00;
      s_d.link.mclk = ~s_q.link.mclk;
    end else begin
      s_d.mdiv = s_q.mdiv + 8'h01;
    end

    // Bit clock divider and serialiser
    if (!s_q.ctrl[0]) begin
      s_d.run = 1'b0;
      s_d.div = 8'h00;
      s_d.pos = 6'h3f;
      s_d.link.sclk = 1'b0;
      s_d.link.lrclk = 1'b0;
      s_d.link.sdata = 2'b00;
    end else if (s_q.div == 8'(SCLK_HALF - 1)) begin
      s_d.run = 1'b1;
      s_d.div = 8'h00;
      s_d.link.sclk = ~s_q.link.sclk;
      // Data moves on the falling edge, steady at the rising one
      if (s_q.link.sclk) begin
        last = 6'({sair_half(s_q.cfg.ratio), 1'b0} - 7'h01);
        if (!s_q.run || s_q.pos >= last) begin
          // Frame start: one word-clock period per frame
          np = 6'h00;
          s_d.cfg = ncfg;
          s_d.shadow = s_q.samp;
          s_d.taken = 1'b1;
          fs = 1'b1; // Frame start event, beats a clear
          s_d.fcnt = s_q.fcnt + 16'h0001;
        end else begin
          np = s_q.pos + 6'h01;
        end
        s_d.pos = np;
        bits = sair_bits(np, s_d.cfg, s_d.shadow, {s_q.shadow.r1[0], s_q.shadow.r0[0]});
        s_d.link.lrclk = bits[2];
        s_d.link.sdata = bits[1:0];
      end
    end else begin
      s_d.div = s_q.div + 8'h01;
    end

    // Register writes; a new frame's sticky flag beats the clear
    if (wr) begin
      unique case (paddr_i)
        `SAIR_OFF_CTRL: s_d.ctrl = pwdata_i[7:0];
        `SAIR_OFF_STATUS: s_d.taken = s_d.taken & ~(pwdata_i[0] & ~fs);
        `SAIR_OFF_L0: s_d.samp.l0 = pwdata_i[23:0];
        `SAIR_OFF_R0: s_d.samp.r0 = pwdata_i[23:0];
        `SAIR_OFF_L1: s_d.samp.l1 = pwdata_i[23:0];
        `SAIR_OFF_R1: s_d.samp.r1 = pwdata_i[23:0];
        `SAIR_OFF_DEVCFG: s_d.devcfg = pwdata_i[4:0];
        default: s_d.ctrl = s_d.ctrl;
      endcase
    end

    // Read data and error captured in the setup cycle
    if (rd) begin
      s_d.pslverr = 1'b0;
      unique case (paddr_i)
        `SAIR_OFF_CTRL: s_d.prdata = {24'h000000, s_q.ctrl};
        `SAIR_OFF_STATUS: s_d.prdata = {s_q.fcnt, 14'h0000, s_q.run, s_q.taken};
        `SAIR_OFF_L0: s_d.prdata = {8'h00, s_q.samp.l0};
        `SAIR_OFF_R0: s_d.prdata = {8'h00, s_q.samp.r0};
        `SAIR_OFF_L1: s_d.prdata = {8'h00, s_q.samp.l1};
        `SAIR_OFF_R1: s_d.prdata = {8'h00, s_q.samp.r1};
        `SAIR_OFF_DEVCFG: s_d.prdata = {27'h0000000, s_q.devcfg};
        default: begin
          s_d.prdata = 32'h00000000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.ctrl <= `SAIR_CTRL_RST;
      s_q.devcfg <= `SAIR_DEVCFG_RST;
      s_q.pos <= 6'h3f;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o = s_q.prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = s_q.pslverr & psel_i & penable_i;
  assign link_o = s_q.link;

  // Auto detection dropped while avoidance or de-emphasis is on
  assign devctl_o.auto_detect = s_q.devcfg[0] & ~s_q.devcfg[3] & ~s_q.devcfg[4];
  assign devctl_o.rate_class = s_q.devcfg[2:1];
  assign devctl_o.avoid_en = s_q.devcfg[3];
  assign devctl_o.deemph_en = s_q.devcfg[4];

endmodule : sair_host

// ==== logic/sair_pkg.sv ====
// Types for the serial audio source controller
package sair_pkg;

  // Serial framing formats
  typedef enum logic [1:0] {
    SAIR_I2S = 2'b00,
    SAIR_LEFT_JUSTIFIED_FORMAT = 2'b01,
    SAIR_RIGHT_JUSTIFIED_FORMAT = 2'b10
  } sair_fmt_t;

  // Frame configuration latched at each frame start
  typedef struct packed {
    logic [1:0] fmt;
    logic [1:0] wlen;
    logic [1:0] ratio;
  } sair_cfg_t;

  // One frame of samples for both data lines
  typedef struct packed {
    logic [23:0] l0;
    logic [23:0] r0;
    logic [23:0] l1;
    logic [23:0] r1;
  } sair_samp_t;

  // Receiver-side control levels
  typedef struct packed {
    logic auto_detect;
    logic [1:0] rate_class;
    logic avoid_en;
    logic deemph_en;
  } sair_devctl_t;

  // Link pins driven toward the receiver
  typedef struct packed {
    logic mclk;
    logic sclk;
    logic lrclk;
    logic [1:0] sdata;
  } sair_link_t;

  // Complete module state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [4:0] devcfg;
    sair_samp_t samp;
    sair_samp_t shadow;
    sair_cfg_t cfg;
    logic run;
    logic [7:0] div;
    logic [7:0] mdiv;
    logic [5:0] pos;
    sair_link_t link;
    logic taken;
    logic [15:0] fcnt;
    logic [31:0] prdata;
    logic pslverr;
  } sair_state_t;

endpackage : sair_pkg

// ==== tb/sair_host_assertions.sv ====
// Port checker for the serial audio source controller
`timescale 1ns/10ps

module sair_host_assertions #(
  parameter int SCLK_HALF = 4,
  parameter int MCLK_HALF = 1
) (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Link and receiver control
  input wire sair_pkg::sair_link_t link_o,
  input wire sair_pkg::sair_devctl_t devctl_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // Bus phases
  sequence s_acc;
    psel_i && penable_i;
  endsequence
  sequence s_bad;
    psel_i && !penable_i && paddr_i > 12'h018 ##1 s_acc;
  endsequence

  // Bus answers, link timing and receiver control
  property p_rdy; s_acc |-> pready_o; endproperty
  property p_bad; s_bad |-> pslverr_o && prdata_o == 32'h0; endproperty
  property p_ok; psel_i && penable_i && paddr_i <= 12'h018 && paddr_i[1:0] == 2'b00 |-> !pslverr_o; endproperty
  property p_lr; link_o.sclk |-> $stable(link_o.lrclk); endproperty
  property p_dat; link_o.sclk |-> $stable(link_o.sdata); endproperty
  property p_auto; devctl_o.avoid_en || devctl_o.deemph_en |-> !devctl_o.auto_detect; endproperty
  property p_half; $rose(link_o.sclk) |-> !$past(link_o.sclk, SCLK_HALF); endproperty
  property p_mclk; $rose(link_o.mclk) |-> ##MCLK_HALF !link_o.mclk; endproperty

  a_rdy: assert property (p_rdy) else $error("ready missing");
  a_bad: assert property (p_bad) else $error("unmapped access not refused");
  a_ok: assert property (p_ok) else $error("mapped access refused");
  a_lr: assert property (p_lr) else $error("word clock moved while bit clock high");
  a_dat: assert property (p_dat) else $error("data moved while bit clock high");
  a_auto: assert property (p_auto) else $error("auto detect left on");
  a_half: assert property (p_half) else $error("bit clock low phase short");
  a_mclk: assert property (p_mclk) else $error("master clock high too long");
endmodule : sair_host_assertions

bind sair_host sair_host_assertions #(.SCLK_HALF(SCLK_HALF), .MCLK_HALF(MCLK_HALF)) u_chk (.clk_i(clk_i),
  .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .link_o(link_o), .devctl_o(devctl_o));

// ==== tb/sair_host_bench.sv ====
// Bench for the serial audio source controller
`timescale 1ns/10ps

module sair_host_bench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  sair_pkg::sair_link_t link_o;
  sair_pkg::sair_devctl_t devctl_o;
  logic [1:0] m_fmt = 2'h0;
  logic [4:0] m_wl = 5'h18;
  logic [23:0] smp [4];
  logic [7:0] ratio;
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int cmp_count = 0;
  logic [23:0] vals [4] = '{24'h8a5c31, 24'h35e7c9, 24'hc3a50f, 24'h5f0a96};

  // Design and receiver
  sair_host u_dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .link_o(link_o), .devctl_o(devctl_o));
  sair_rx_model u_rx (.clk_i(clk_i), .link_i(link_o), .fmt_i(m_fmt), .wlen_i(m_wl), .smp_o(smp), .ratio_o(ratio));

  // Clock
  always #50 clk_i = ~clk_i;

  task automatic test_done();
    $display("Compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s exp %h got %h", nm, exp, got);
      num_errors++;
    end
  endtask : chk

  // One bus transfer, setup then access until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      test_done();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  function automatic logic [23:0] sx(input logic [23:0] v, input int w);
    logic signed [23:0] s;
    s = v << (24 - w);
    return s >>> (24 - w);
  endfunction : sx

  task automatic t_reset();
    chk("devctl", 32'(devctl_o), 32'h10);
    apb(1'b0, 12'h018, 32'h0);
    chk("devcfg", rd, 32'h1);
    apb(1'b1, 12'h01c, 32'hffffffff);
    chk("wr_err", 32'(er), 32'h1);
    apb(1'b0, 12'h01c, 32'h0);
    chk("rd_err", {rd[30:0], er}, 32'h1);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_devcfg();
    logic [4:0] tab [4] = '{5'h06, 5'h0b, 5'h13, 5'h01};
    foreach (tab[i]) begin
      apb(1'b1, 12'h018, 32'(tab[i]));
      @(posedge clk_i);
      chk("devctl", 32'(devctl_o), 32'({tab[i][0] & ~tab[i][3] & ~tab[i][4], tab[i][2:1], tab[i][3], tab[i][4]}));
    end
    $display("t_devcfg done");
  endtask : t_devcfg

  task automatic t_frames();
    logic [7:0] ctl [8] = '{8'hd9, 8'h3b, 8'h35, 8'h1b, 8'h05, 8'h69, 8'h5d, 8'h39};
    int wl [8] = '{24, 24, 20, 16, 16, 18, 24, 24};
    int fr [8] = '{64, 48, 48, 32, 32, 64, 64, 48};
    int n0;
    int k;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h000, 32'h0);
      for (int i = 0; i < 4; i++) begin
        apb(1'b1, 12'h008 + 12'(4 * i), 32'(vals[i]));
      end
      m_fmt <= ctl[c][2:1];
      m_wl <= 5'(wl[c]);
      apb(1'b0, 12'h004, 32'h0);
      n0 = int'(rd[31:16]);
      apb(1'b1, 12'h000, 32'(ctl[c]));
      k = 0;
      do begin
        apb(1'b0, 12'h004, 32'h0);
        k++;
      end while (int'(rd[31:16]) < n0 + 3 && k < 2000);
      if (k >= 2000) begin
        num_errors++;
        test_done();
      end
      chk("ratio", 32'(ratio), 32'(fr[c]));
      chk("status", 32'(rd[1:0]), 32'h3);
      for (int i = 0; i < 4; i++) begin
        chk("sample", 32'(smp[i]), 32'(sx(vals[i], wl[c])));
      end
    end
    // Stop the link, then clear the sticky frame flag
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk("status_clr", 32'(rd[1:0]), 32'h0);
    $display("t_frames done");
  endtask : t_frames

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_devcfg();
    t_frames();
    test_done();
  end
endmodule : sair_host_bench

// ==== tb/sair_rx_model.sv ====
// Receiver model for the serial audio link
`timescale 1ns/10ps

module sair_rx_model (
  // Clock and link
  input wire logic clk_i,
  input wire sair_pkg::sair_link_t link_i,
  // Framing the receiver is set to
  input wire logic [1:0] fmt_i,
  input wire logic [4:0] wlen_i,
  // Received words and bit clocks per frame
  output logic [23:0] smp_o [4],
  output logic [7:0] ratio_o
);
  logic sck_q = 1'b0;
  logic lr_q = 1'b0;
  logic signed [31:0] t;
  logic [31:0] sh [2];
  int pos = 0;
  int cnt = 0;

  // Sample on bit clock rise, close a slot at each word clock change
  always @(posedge clk_i) begin
    sck_q <= link_i.sclk;
    if (link_i.sclk && !sck_q) begin
      if (link_i.lrclk != lr_q) begin
        for (int d = 0; d < 2; d++) begin
          // Word filling an I2S slot ends one bit into the next slot
          if (fmt_i == 2'h0 && pos == int'(wlen_i)) begin
            sh[d] = {sh[d][30:0], link_i.sdata[d]};
          end
          t = sh[d] << (32 - wlen_i);
          smp_o[d * 2 + int'(lr_q == (fmt_i == 2'h0))] <= 24'(t >>> (32 - wlen_i));
        end
        if (link_i.lrclk) begin
          ratio_o <= 8'(cnt);
          cnt = 0;
        end
        pos = 0;
      end
      for (int d = 0; d < 2; d++) begin
        if (fmt_i == 2'h2 || (pos >= int'(fmt_i == 2'h0) && pos < int'(fmt_i == 2'h0) + wlen_i)) begin
          sh[d] = {sh[d][30:0], link_i.sdata[d]};
        end
      end
      pos++;
      cnt++;
      lr_q <= link_i.lrclk;
    end
  end
endmodule : sair_rx_model
